// ---- core/rx_irq_pkg.sv ----
// constants for the receiver status and interrupt mask block
// assumes a plain register port with byte-wide registers at printed offsets
package rx_irq_pkg;
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 8;
  localparam int          NUM_SRC          = 8;
  localparam logic [7:0]  OFS_SRC_STATUS   = 8'h14;
  localparam logic [7:0]  OFS_SLIP_STATUS  = 8'h15;
  localparam logic [7:0]  OFS_MASK_MAIN    = 8'h16;
  localparam logic [7:0]  OFS_MASK_SLIP    = 8'h17;
  localparam logic [7:0]  OFS_MODE_1       = 8'h18;
  localparam logic [7:0]  OFS_MODE_2       = 8'h19;
  localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h1A;
  localparam logic [7:0]  OFS_IRQ_STATUS_2 = 8'h1B;
  localparam logic [7:0]  MASK_RESET       = 8'h00;
  localparam logic [7:0]  MODE_RESET       = 8'h00;
  localparam int          BIT_BUF_XFER     = 0;
  localparam int          BIT_SLIP         = 0;
  localparam int          SLIP_WINDOW_PCT  = 5;
  typedef enum logic [1:0]
  {
    TRIG_RISE    = 2'b00,
    TRIG_FALL    = 2'b01,
    TRIG_LEVEL   = 2'b10,
    TRIG_RSVD    = 2'b11
  } trig_mode_t;
endpackage

// ---- core/receiver_status_interrupt_mask.sv ----
// receiver status flags, interrupt masks, trigger modes and sticky interrupt status
// assumes status condition inputs come from other clock domains and frame strobes are async
// Summary of operation
// - the buffer transfer flag reads 1 once a receive-to-user buffer transfer completes, else 0.
// - the slip status register is read-only with bits 7..1 zero and bit 0 the slip flag.
// - the slip flag is 1 when an output sample was dropped or repeated, else 0.
// - the slip condition raises an interrupt only when its mask bit at 0x17 is set.
// - with one slave port fed by the receiver, the slip flag and interrupt apply to that port.
// - a slip is flagged when the slave word clock edge falls within five percent of the frame edge.
// - the main mask register holds eight enables in the status bit order.
// - mask bits reset to 0 (masked) and writing 1 enables the matching interrupt.
// - the slip mask register reads zero in bits 7..1 with the slip enable in bit 0.
// - the slip mask bit resets to 0 and 1 enables the slip interrupt.
// - each source has a two-bit trigger: rising, falling, level, or reserved.
// - conditions of the main status register interrupt only when unmasked at 0x16.
`timescale 1ns/1ps
`default_nettype none
module receiver_status_interrupt_mask
  import rx_irq_pkg::*;
#(
  parameter int FRAME_CYCLES = 64
)
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [DATA_W-1:0]     wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [DATA_W-1:0]     rdata_o,
  input  wire logic [NUM_SRC-1:0]    src_cond_i,
  input  wire logic                  frame_edge_i,
  input  wire logic                  word_clock_i,
  output logic                       irq_o
);
  import rx_irq_pkg::*;

  // status, frame edge and word clock inputs pass two flops before use; the register port inputs are used directly
  logic [NUM_SRC+1:0] meta_reg;
  logic [NUM_SRC+1:0] sync_reg;
  logic [NUM_SRC+1:0] prev_reg;
  logic [DATA_W-1:0]  mask_main_reg;
  logic               mask_slip_reg;
  logic [15:0]        mode_reg;
  logic [NUM_SRC-1:0] irq_stat_reg;
  logic               slip_irq_reg;
  logic               slip_flag_reg;
  logic [15:0]        since_frame_reg;
  logic [DATA_W-1:0]  rdata_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= {word_clock_i, frame_edge_i, src_cond_i};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  wire logic [NUM_SRC-1:0] cond      = sync_reg[NUM_SRC-1:0];
  wire logic [NUM_SRC-1:0] cond_prev = prev_reg[NUM_SRC-1:0];
  wire logic frame_rise = sync_reg[NUM_SRC] & ~prev_reg[NUM_SRC];
  wire logic word_rise  = sync_reg[NUM_SRC+1] & ~prev_reg[NUM_SRC+1];

  function automatic logic trig_hit(input logic [1:0] m, input logic now, input logic was);
    case (m)
      TRIG_RISE:  trig_hit = now & ~was;
      TRIG_FALL:  trig_hit = ~now & was;
      TRIG_LEVEL: trig_hit = now;
      default:    trig_hit = 1'b0; // reserved mode never fires
    endcase
  endfunction

  // mode bit pairs: source i uses mode_reg[2i+1:2i]; 0x18 holds sources 3..0
  wire logic [NUM_SRC-1:0] src_hit;
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_trig
      assign src_hit[g] = trig_hit(mode_reg[2*g+1 -: 2], cond[g], cond_prev[g]);
    end
  endgenerate

  // slip window: five percent of a frame either side of the receiver frame edge
  localparam int WIN_CYCLES = (FRAME_CYCLES * SLIP_WINDOW_PCT) / 100;
  wire logic in_window = (since_frame_reg <= 16'(WIN_CYCLES))
                       | (since_frame_reg >= 16'(FRAME_CYCLES - WIN_CYCLES));
  // single slave port assumed, so one flag and one interrupt serve it
  wire logic slip_event = word_rise & in_window;

  wire logic sel_mask_main = (addr_i == OFS_MASK_MAIN);
  wire logic sel_mask_slip = (addr_i == OFS_MASK_SLIP);
  wire logic sel_mode_1    = (addr_i == OFS_MODE_1);
  wire logic sel_mode_2    = (addr_i == OFS_MODE_2);
  wire logic sel_irq_main  = (addr_i == OFS_IRQ_STATUS);
  wire logic sel_irq_slip  = (addr_i == OFS_IRQ_STATUS_2);
  wire logic sel_slip_stat = (addr_i == OFS_SLIP_STATUS);
  wire logic [NUM_SRC-1:0] irq_w1c = (wr_i && sel_irq_main) ? wdata_i : '0;
  wire logic slip_w1c  = wr_i && sel_irq_slip && wdata_i[BIT_SLIP];
  // reading the slip status register consumes the flag, but a new slip wins
  wire logic slip_rdclr = rd_i && sel_slip_stat;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      since_frame_reg <= '0;
    else if (frame_rise)
      since_frame_reg <= '0;
    else if (since_frame_reg != 16'hFFFF)
      since_frame_reg <= since_frame_reg + 16'h0001;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mask_main_reg <= MASK_RESET;
      mask_slip_reg <= 1'b0;
      mode_reg      <= {MODE_RESET, MODE_RESET};
    end
    else if (wr_i)
    begin
      if (sel_mask_main)
        mask_main_reg <= wdata_i;
      if (sel_mask_slip)
        mask_slip_reg <= wdata_i[BIT_SLIP];
      if (sel_mode_1)
        mode_reg[7:0] <= wdata_i;
      if (sel_mode_2)
        mode_reg[15:8] <= wdata_i;
    end
  end

  // sticky flags: set wins over clear in the same cycle
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_stat_reg  <= '0;
      slip_irq_reg  <= 1'b0;
      slip_flag_reg <= 1'b0;
    end
    else
    begin
      irq_stat_reg  <= (irq_stat_reg & ~irq_w1c) | src_hit;
      slip_irq_reg  <= (slip_irq_reg & ~slip_w1c) | slip_event;
      slip_flag_reg <= (slip_flag_reg & ~slip_rdclr) | slip_event;
    end
  end

  assign irq_o = |(irq_stat_reg & mask_main_reg) | (slip_irq_reg & mask_slip_reg);

  logic [DATA_W-1:0] rd_mux;
  always_comb
  begin
    case (addr_i)
      OFS_SRC_STATUS:   rd_mux = cond;
      OFS_SLIP_STATUS:  rd_mux = {7'h00, slip_flag_reg};
      OFS_MASK_MAIN:    rd_mux = mask_main_reg;
      OFS_MASK_SLIP:    rd_mux = {7'h00, mask_slip_reg};
      OFS_MODE_1:       rd_mux = mode_reg[7:0];
      OFS_MODE_2:       rd_mux = mode_reg[15:8];
      OFS_IRQ_STATUS:   rd_mux = irq_stat_reg;
      OFS_IRQ_STATUS_2: rd_mux = {7'h00, slip_irq_reg};
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_reg <= '0;
    else if (rd_i)
      rdata_reg <= rd_mux;
    else
      rdata_reg <= '0;
  end
  assign rdata_o = rdata_reg;

  sequence s_slip_seen;
    slip_event;
  endsequence

  sequence s_slip_read;
    rd_i && sel_slip_stat;
  endsequence

  a_slip_flag_set: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_slip_seen |=> slip_flag_reg) else $error("slip flag not set after slip");
  a_slip_rd_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_slip_read |=> rdata_o[7:1] == 7'h00) else $error("slip status upper bits not zero");
  a_slip_rd_value: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_slip_read ##0 slip_flag_reg |=> rdata_o[0]) else $error("slip flag not read back");
  a_slip_masked_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!mask_slip_reg && (irq_stat_reg & mask_main_reg) == '0) |-> !irq_o)
    else $error("interrupt with all sources masked");
  a_slip_irq_out: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mask_slip_reg && slip_irq_reg) |-> irq_o) else $error("unmasked slip gives no irq");
  a_mask_write_back: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && sel_mask_main) ##2 (rd_i && sel_mask_main && !$past(wr_i))
    |=> rdata_o == $past(wdata_i, 3)) else $error("main mask readback wrong");
  a_mask_slip_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && sel_mask_slip) |=> rdata_o[7:1] == 7'h00) else $error("slip mask upper bits set");
  a_main_irq_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ((irq_stat_reg & mask_main_reg) != '0) |-> irq_o) else $error("unmasked source no irq");
  a_rise_trigger: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mode_reg[1:0] == TRIG_RISE && cond[0] && !cond_prev[0]) |=> irq_stat_reg[0])
    else $error("rising trigger missed");
  a_rsvd_trigger: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mode_reg[1:0] == TRIG_RSVD && !irq_stat_reg[0] && !irq_w1c[0]) |=> !irq_stat_reg[0])
    else $error("reserved mode fired");
  a_xfer_status: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == OFS_SRC_STATUS) |=> rdata_o[BIT_BUF_XFER] == $past(cond[BIT_BUF_XFER]))
    else $error("transfer flag readback wrong");
  a_slip_window: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (word_rise && !in_window && !slip_flag_reg) |=> !slip_flag_reg)
    else $error("slip outside window");

  // sequences for the clear and frame steps of the sticky and window logic
  sequence s_frame_start;
    frame_rise;
  endsequence

  sequence s_slip_clear;
    slip_w1c && !slip_event;
  endsequence

  sequence s_src_clear;
    irq_w1c[0] && !src_hit[0];
  endsequence

  // read data must not linger, or software could read a stale byte
  a_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !rd_i |=> rdata_o == 8'h00) else $error("read data not returned to zero");

  a_unmapped_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && !sel_mask_main && !sel_mask_slip && !sel_mode_1 && !sel_mode_2
     && !sel_irq_main && !sel_irq_slip && !sel_slip_stat && addr_i != OFS_SRC_STATUS)
    |=> rdata_o == 8'h00) else $error("unmapped read not zero");

  a_slip_mask_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && sel_mask_slip) |=> rdata_o[0] == $past(mask_slip_reg))
    else $error("slip mask readback wrong");

  a_mask_main_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !wr_i |=> $stable(mask_main_reg)) else $error("main mask changed without write");

  a_mask_slip_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !wr_i |=> $stable(mask_slip_reg)) else $error("slip mask changed without write");

  a_mode_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !wr_i |=> $stable(mode_reg)) else $error("mode changed without write");

  a_fall_trigger: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mode_reg[1:0] == TRIG_FALL && !cond[0] && cond_prev[0]) |=> irq_stat_reg[0])
    else $error("falling trigger missed");

  a_level_trigger: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mode_reg[1:0] == TRIG_LEVEL && cond[0]) |=> irq_stat_reg[0])
    else $error("level trigger missed");

  a_sticky_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (irq_stat_reg[0] && !irq_w1c[0]) |=> irq_stat_reg[0])
    else $error("sticky source bit lost");

  a_sticky_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_src_clear |=> !irq_stat_reg[0]) else $error("sticky source bit not cleared");

  a_slip_irq_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (slip_irq_reg && !slip_w1c) |=> slip_irq_reg) else $error("sticky slip bit lost");

  a_slip_irq_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_slip_clear |=> !slip_irq_reg) else $error("sticky slip bit not cleared");

  a_slip_flag_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_slip_read ##0 !slip_event |=> !slip_flag_reg) else $error("slip flag kept after read");

  a_slip_flag_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!slip_flag_reg && !slip_event) |=> !slip_flag_reg) else $error("slip flag set with no slip");

  a_window_count: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_frame_start |=> since_frame_reg == 16'h0000) else $error("frame counter not restarted");

  a_src_irq_out: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (irq_stat_reg[0] && mask_main_reg[0]) |-> irq_o) else $error("unmasked source bit no irq");

  a_quiet_all: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (irq_stat_reg == '0 && !slip_irq_reg) |-> !irq_o) else $error("irq with nothing pending");

endmodule
`default_nettype wire

// ---- verif/receiver_status_interrupt_mask_test.sv ----
// testbench for the receiver status and interrupt mask block
// assumes the register port answers a read one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module receiver_status_interrupt_mask_test;
  import rx_irq_pkg::*;
  // short frame keeps the slip window at one cycle
  localparam int FRAMES = 20;
  logic               clk_sys_i;
  logic               rst_i;
  logic [ADDR_W-1:0]  addr_i;
  logic [DATA_W-1:0]  wdata_i;
  logic               wr_i;
  logic               rd_i;
  logic [DATA_W-1:0]  rdata_o;
  logic [NUM_SRC-1:0] src_cond_i;
  logic               frame_edge_i;
  logic               word_clock_i;
  logic               irq_o;
  int                 fail_count;
  int                 num_checks;
  int                 cycles;
  logic [DATA_W-1:0]  got;

  receiver_status_interrupt_mask #(.FRAME_CYCLES(FRAMES)) DUT
  (
    .clk_sys_i    (clk_sys_i),
    .rst_i        (rst_i),
    .addr_i       (addr_i),
    .wdata_i      (wdata_i),
    .wr_i         (wr_i),
    .rd_i         (rd_i),
    .rdata_o      (rdata_o),
    .src_cond_i   (src_cond_i),
    .frame_edge_i (frame_edge_i),
    .word_clock_i (word_clock_i),
    .irq_o        (irq_o)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // a hang in any wait below ends here rather than running forever
  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      fail_count = fail_count + 1;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      fail_count = fail_count + 1;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1 got = rdata_o;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic test_reset();
    rd(OFS_MASK_MAIN);   chk("mask_main", MASK_RESET, got);
    rd(OFS_MASK_SLIP);   chk("mask_slip", 8'h00, got);
    rd(OFS_SLIP_STATUS); chk("slip_status", 8'h00, got);
    chk("irq", 8'h00, {7'h0, irq_o});
    $display("test_reset done");
  endtask

  task automatic test_masks();
    wr(OFS_MASK_MAIN, 8'hA5);
    rd(OFS_MASK_MAIN);   chk("mask_main", 8'hA5, got);
    wr(OFS_MASK_SLIP, 8'hFF);
    rd(OFS_MASK_SLIP);   chk("mask_slip", 8'h01, got);
    wr(OFS_SLIP_STATUS, 8'hFF);
    rd(OFS_SLIP_STATUS); chk("slip_status", 8'h00, got);
    rd(8'h30);           chk("unmapped", 8'h00, got);
    rd(OFS_MASK_MAIN);   settle(1); chk("rdata_idle", 8'h00, rdata_o);
    wr(OFS_MASK_MAIN, 8'h00);
    wr(OFS_MASK_SLIP, 8'h00);
    $display("test_masks done");
  endtask

  task automatic test_buffer();
    @(posedge clk_sys_i);
    src_cond_i <= 8'h01;
    settle(5);
    rd(OFS_SRC_STATUS); chk("buf_flag", 8'h01, got);
    chk("irq", 8'h00, {7'h0, irq_o});
    wr(OFS_MASK_MAIN, 8'h01);
    settle(1); chk("irq", 8'h01, {7'h0, irq_o});
    wr(OFS_IRQ_STATUS, 8'h01);
    settle(1); chk("irq", 8'h00, {7'h0, irq_o});
    src_cond_i <= 8'h00;
    settle(5);
    $display("test_buffer done");
  endtask

  task automatic test_mode();
    wr(OFS_MODE_1, 8'h01);
    src_cond_i <= 8'h01;
    settle(5); chk("irq", 8'h00, {7'h0, irq_o});
    src_cond_i <= 8'h00;
    settle(5); chk("irq", 8'h01, {7'h0, irq_o});
    wr(OFS_IRQ_STATUS, 8'h01);
    wr(OFS_MODE_1, 8'h02);
    settle(3); chk("irq", 8'h00, {7'h0, irq_o});
    src_cond_i <= 8'h01;
    settle(5); chk("irq", 8'h01, {7'h0, irq_o});
    src_cond_i <= 8'h00;
    settle(5);
    wr(OFS_IRQ_STATUS, 8'h01);
    settle(1); chk("irq", 8'h00, {7'h0, irq_o});
    wr(OFS_MASK_MAIN, 8'h00);
    wr(OFS_MODE_1, MODE_RESET);
    $display("test_mode done");
  endtask

  task automatic test_slip();
    frame_edge_i <= 1'b1;
    settle(10);
    word_clock_i <= 1'b1;
    settle(6);
    rd(OFS_SLIP_STATUS); chk("slip_far", 8'h00, got);
    frame_edge_i <= 1'b0;
    word_clock_i <= 1'b0;
    settle(3);
    // both edges on one clock: zero cycles apart, inside the window
    frame_edge_i <= 1'b1;
    word_clock_i <= 1'b1;
    settle(6); chk("irq", 8'h00, {7'h0, irq_o});
    wr(OFS_MASK_SLIP, 8'h01);
    settle(1); chk("irq", 8'h01, {7'h0, irq_o});
    rd(OFS_SLIP_STATUS); chk("slip_near", 8'h01, got);
    wr(OFS_IRQ_STATUS_2, 8'h01);
    settle(1); chk("irq", 8'h00, {7'h0, irq_o});
    $display("test_slip done");
  endtask

  initial
  begin
    rst_i        = 1'b1;
    addr_i       = 8'h00;
    wdata_i      = 8'h00;
    wr_i         = 1'b0;
    rd_i         = 1'b0;
    src_cond_i   = 8'h00;
    frame_edge_i = 1'b0;
    word_clock_i = 1'b0;
    fail_count   = 0;
    num_checks   = 0;
    cycles       = 0;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    test_reset();
    test_masks();
    test_buffer();
    test_mode();
    test_slip();
    close_out();
  end
endmodule
`default_nettype wire
